// >>> rtl/swobj_ctrl.v
// switchgear object monitoring and open/close command control
`timescale 1ns/1ps
`default_nettype none
`include "swobj_map.vh"
module swobj_ctrl #(
  parameter integer TICK_CYC = `SWOBJ_TICK_CYC,
  parameter integer NRELAY = 8,
  parameter integer NSRC = 4
) (
  input wire core_clk_i,
  input wire srst_i,
  input wire [NSRC-1:0] open_pos_src_i,
  input wire [NSRC-1:0] closed_pos_src_i,
  input wire [NSRC-1:0] racked_in_src_i,
  input wire [NSRC-1:0] racked_out_src_i,
  input wire [NSRC-1:0] ready_src_i,
  input wire [NSRC-1:0] sync_ok_src_i,
  input wire [1:0] open_logic_signal_select_i,
  input wire [1:0] closed_logic_signal_select_i,
  input wire [1:0] in_logic_signal_select_i,
  input wire [1:0] out_logic_signal_select_i,
  input wire [1:0] ready_logic_signal_select_i,
  input wire [1:0] sync_logic_signal_select_i,
  input wire [1:0] object_type_i,
  input wire sync_use_i,
  input wire [1:0] ready_use_i,
  input wire [15:0] open_pulse_ms_i,
  input wire [15:0] close_pulse_ms_i,
  input wire [15:0] term_ms_i,
  input wire [2:0] open_output_relay_select_i,
  input wire [2:0] close_output_relay_select_i,
  input wire open_req_i,
  input wire close_req_i,
  input wire open_interlock_i,
  input wire close_interlock_i,
  input wire clear_stats_i,
  output reg [NRELAY-1:0] relay_o,
  output reg open_cmd_o,
  output reg close_cmd_o,
  output reg [1:0] breaker_status_o,
  output reg [2:0] cart_status_o,
  output reg [31:0] open_ok_cnt_o,
  output reg [31:0] close_ok_cnt_o,
  output reg [31:0] open_fail_cnt_o,
  output reg [31:0] close_fail_cnt_o,
  output reg clear_stats_o,
  output reg ctrl_error_o,
  output reg busy_o
);
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_PULSE = 2'h1;
  localparam [1:0] S_WAIT = 2'h2;

  // pick one of the candidate sources for a status input
  function src_pick;
    input [NSRC-1:0] src;
    input [1:0] sel;
    begin
      src_pick = src[sel];
    end
  endfunction

  wire [5:0] raw;
  wire [5:0] fld;
  assign raw = {src_pick(sync_ok_src_i, sync_logic_signal_select_i),
                src_pick(ready_src_i, ready_logic_signal_select_i),
                src_pick(racked_out_src_i, out_logic_signal_select_i),
                src_pick(racked_in_src_i, in_logic_signal_select_i),
                src_pick(closed_pos_src_i, closed_logic_signal_select_i),
                src_pick(open_pos_src_i, open_logic_signal_select_i)};

  swobj_sync #(
    .W(6)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i(raw),
    .sync_o(fld)
  );

  wire pos_open = fld[0];
  wire pos_closed = fld[1];
  wire cart_in = fld[2];
  wire cart_out = fld[3];
  wire obj_ready = fld[4];
  wire sync_ok = fld[5];

  // millisecond enable divider: keeps the pulse and timeout counters small
  reg [15:0] div_q;
  reg tick_q;
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q == TICK_CYC[15:0] - 16'h0001) begin
      div_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  wire is_wd = (object_type_i == `SWOBJ_TYPE_WD);
  wire is_brk = is_wd || (object_type_i == `SWOBJ_TYPE_CB);
  wire can_ctrl = (object_type_i != `SWOBJ_TYPE_ES);

  reg [1:0] pos_st;
  always @* begin
    case ({pos_closed, pos_open})
      2'b01: pos_st = `SWOBJ_ST_OPEN;
      2'b10: pos_st = `SWOBJ_ST_CLOSED;
      2'b11: pos_st = `SWOBJ_ST_BAD;
      default: pos_st = `SWOBJ_ST_MID;
    endcase
  end

  reg [2:0] cart_st;
  always @* begin
    if (!is_wd) begin
      cart_st = `SWOBJ_WD_NONE;
    end else if (cart_in && cart_out) begin
      cart_st = `SWOBJ_WD_BAD;
    end else if (cart_in) begin
      cart_st = `SWOBJ_WD_IN;
    end else if (cart_out) begin
      cart_st = `SWOBJ_WD_OUT;
    end else begin
      cart_st = `SWOBJ_WD_MID;
    end
  end

  // close gating applies to breaker types only
  reg ready_ok;
  always @* begin
    if (!is_brk || ready_use_i == `SWOBJ_RDY_OFF) begin
      ready_ok = 1'b1;
    end else if (ready_use_i == `SWOBJ_RDY_LOW) begin
      ready_ok = !obj_ready;
    end else begin
      ready_ok = obj_ready;
    end
  end
  wire sync_pass = !is_brk || !sync_use_i || sync_ok;
  wire cart_ok = !is_wd || (cart_in && !cart_out);
  wire close_gate = ready_ok && sync_pass;
  wire close_lock = close_interlock_i || !cart_ok;

  reg [1:0] st_q;
  reg dir_close_q;
  reg [15:0] ms_q;
  reg open_inc;
  reg close_inc;
  reg open_fail_inc;
  reg close_fail_inc;
  wire reached = dir_close_q ? (pos_st == `SWOBJ_ST_CLOSED) : (pos_st == `SWOBJ_ST_OPEN);
  wire [15:0] pulse_lim = dir_close_q ? close_pulse_ms_i : open_pulse_ms_i;

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      st_q <= S_IDLE;
      dir_close_q <= 1'b0;
      ms_q <= 16'h0000;
      open_cmd_o <= 1'b0;
      close_cmd_o <= 1'b0;
      ctrl_error_o <= 1'b0;
      busy_o <= 1'b0;
      open_inc <= 1'b0;
      close_inc <= 1'b0;
      open_fail_inc <= 1'b0;
      close_fail_inc <= 1'b0;
    end else begin
      open_inc <= 1'b0;
      close_inc <= 1'b0;
      open_fail_inc <= 1'b0;
      close_fail_inc <= 1'b0;
      ctrl_error_o <= 1'b0;
      case (st_q)
        S_IDLE: begin
          ms_q <= 16'h0000;
          if (open_req_i && can_ctrl) begin
            if (open_interlock_i) begin
              open_fail_inc <= 1'b1;
            end else begin
              st_q <= S_PULSE;
              dir_close_q <= 1'b0;
              open_cmd_o <= 1'b1;
              busy_o <= 1'b1;
            end
          end else if (close_req_i && can_ctrl) begin
            if (!close_gate || close_lock) begin
              close_fail_inc <= 1'b1;
            end else begin
              st_q <= S_PULSE;
              dir_close_q <= 1'b1;
              close_cmd_o <= 1'b1;
              busy_o <= 1'b1;
            end
          end
        end
        S_PULSE, S_WAIT: begin
          if (tick_q) begin
            ms_q <= ms_q + 16'h0001;
          end
          // a type change to earth switch mid-control drops the command at once
          if (!can_ctrl) begin
            open_cmd_o <= 1'b0;
            close_cmd_o <= 1'b0;
            busy_o <= 1'b0;
            st_q <= S_IDLE;
          end else if (reached) begin
            open_cmd_o <= 1'b0;
            close_cmd_o <= 1'b0;
            busy_o <= 1'b0;
            st_q <= S_IDLE;
            open_inc <= !dir_close_q;
            close_inc <= dir_close_q;
          end else if (tick_q && ms_q + 16'h0001 >= term_ms_i) begin
            open_cmd_o <= 1'b0;
            close_cmd_o <= 1'b0;
            busy_o <= 1'b0;
            st_q <= S_IDLE;
            ctrl_error_o <= 1'b1;
            open_fail_inc <= !dir_close_q;
            close_fail_inc <= dir_close_q;
          end else if (st_q == S_PULSE && tick_q && ms_q + 16'h0001 >= pulse_lim) begin
            open_cmd_o <= 1'b0;
            close_cmd_o <= 1'b0;
            st_q <= S_WAIT;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // next count: clear wins, and a full counter holds rather than wrapping to look cleared
  function [31:0] cnt_next;
    input [31:0] cnt;
    input inc;
    input clr;
    begin
      if (clr) begin
        cnt_next = 32'h00000000;
      end else if (inc && cnt != 32'hffffffff) begin
        cnt_next = cnt + 32'h00000001;
      end else begin
        cnt_next = cnt;
      end
    end
  endfunction

  wire clr_go = clear_stats_i && !clear_stats_o;
  // clear flag is self-clearing: high for exactly one cycle after a request
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      clear_stats_o <= 1'b0;
      open_ok_cnt_o <= 32'h00000000;
      close_ok_cnt_o <= 32'h00000000;
      open_fail_cnt_o <= 32'h00000000;
      close_fail_cnt_o <= 32'h00000000;
    end else begin
      clear_stats_o <= clr_go;
      open_ok_cnt_o <= cnt_next(open_ok_cnt_o, open_inc, clr_go);
      close_ok_cnt_o <= cnt_next(close_ok_cnt_o, close_inc, clr_go);
      open_fail_cnt_o <= cnt_next(open_fail_cnt_o, open_fail_inc, clr_go);
      close_fail_cnt_o <= cnt_next(close_fail_cnt_o, close_fail_inc, clr_go);
    end
  end

  // status and relay routing registered so outputs come from flops
  genvar g;
  wire [NRELAY-1:0] relay_d;
  generate
    for (g = 0; g < NRELAY; g = g + 1) begin : g_relay
      assign relay_d[g] = (open_cmd_o && open_output_relay_select_i == g) ||
                          (close_cmd_o && close_output_relay_select_i == g);
    end
  endgenerate

  // one process drives the whole relay word; the relay lags its command by one flop
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      relay_o <= {NRELAY{1'b0}};
    end else begin
      relay_o <= relay_d;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      breaker_status_o <= `SWOBJ_ST_MID;
      cart_status_o <= `SWOBJ_WD_NONE;
    end else begin
      breaker_status_o <= pos_st;
      cart_status_o <= cart_st;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/swobj_map.vh
// constants for the switchgear object control block
`ifndef SWOBJ_MAP_VH
`define SWOBJ_MAP_VH
`define SWOBJ_CLK_HZ 40000000
`define SWOBJ_PULSE_MS 200
`define SWOBJ_TERM_MS 10000
`define SWOBJ_TICK_CYC 40000
`define SWOBJ_TYPE_WD 2'h0
`define SWOBJ_TYPE_CB 2'h1
`define SWOBJ_TYPE_DC 2'h2
`define SWOBJ_TYPE_ES 2'h3
`define SWOBJ_RDY_HIGH 2'h0
`define SWOBJ_RDY_LOW 2'h1
`define SWOBJ_RDY_OFF 2'h2
`define SWOBJ_ST_MID 2'h0
`define SWOBJ_ST_OPEN 2'h1
`define SWOBJ_ST_CLOSED 2'h2
`define SWOBJ_ST_BAD 2'h3
`define SWOBJ_WD_MID 3'h0
`define SWOBJ_WD_OUT 3'h1
`define SWOBJ_WD_IN 3'h2
`define SWOBJ_WD_BAD 3'h3
`define SWOBJ_WD_NONE 3'h4
`endif

// >>> rtl/swobj_sync.v
// two-flop synchroniser bank for field status inputs
`timescale 1ns/1ps
`default_nettype none
module swobj_sync #(
  parameter W = 6
) (
  input wire core_clk_i,
  input wire srst_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule
`default_nettype wire

// >>> tb/swobj_checker.sv
// assertions on the switchgear object control ports
`timescale 1ns/1ps
`default_nettype none
module swobj_checker #(
  parameter integer TICK_CYC = 4,
  parameter integer NSRC = 4
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [NSRC-1:0] sync_ok_src_i,
  input wire logic [1:0] sync_logic_signal_select_i,
  input wire logic [1:0] object_type_i,
  input wire logic sync_use_i,
  input wire logic [15:0] close_pulse_ms_i,
  input wire logic open_req_i,
  input wire logic close_req_i,
  input wire logic open_interlock_i,
  input wire logic clear_stats_i,
  input wire logic open_cmd_o,
  input wire logic close_cmd_o,
  input wire logic [31:0] close_ok_cnt_o,
  input wire logic [31:0] close_fail_cnt_o,
  input wire logic clear_stats_o,
  input wire logic busy_o
);
  wire sync_bit = sync_ok_src_i[sync_logic_signal_select_i];
  logic [31:0] ccnt_q;
  // slack of one tick since the ms tick may be free running
  always @(posedge core_clk_i) begin
    if (srst_i || !close_cmd_o) ccnt_q <= 32'h0;
    else ccnt_q <= ccnt_q + 32'h1;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_settled;
    $stable({sync_ok_src_i, sync_logic_signal_select_i});
  endsequence
  sequence s_close_try;
    !busy_o && close_req_i && !open_req_i && object_type_i < 2'h2;
  endsequence
  a_sync_refuse:
    assert property (s_settled[*4] ##0 s_close_try ##0 (sync_use_i && !sync_bit) |=> !close_cmd_o)
    else $error("close issued without sync permission");
  a_earth_no_cmd:
    assert property (object_type_i == 2'h3 |=> !open_cmd_o && !close_cmd_o)
    else $error("earth switch got a command");
  a_cmd_excl:
    assert property (!(open_cmd_o && close_cmd_o)) else $error("open and close at once");
  a_open_answer:
    assert property (!busy_o && open_req_i && object_type_i != 2'h3 && !open_interlock_i |=> open_cmd_o && busy_o)
    else $error("open request not answered");
  a_fail_step:
    assert property ($changed(close_fail_cnt_o) |-> close_fail_cnt_o == $past(close_fail_cnt_o) + 32'h1
      || close_fail_cnt_o == 32'h0) else $error("fail count jumped");
  a_clear_zero:
    assert property (clear_stats_i |-> ##[1:2] ({close_ok_cnt_o, close_fail_cnt_o} == 64'h0))
    else $error("counters not cleared");
  a_clear_self:
    assert property (clear_stats_o |=> !clear_stats_o) else $error("clear did not return idle");
  a_pulse_max:
    assert property (ccnt_q <= (close_pulse_ms_i + 32'h1) * TICK_CYC) else $error("close pulse too long");
endmodule
bind swobj_ctrl swobj_checker #(.TICK_CYC(TICK_CYC), .NSRC(NSRC)) u_swobj_checker (.core_clk_i(core_clk_i),
  .srst_i(srst_i), .sync_ok_src_i(sync_ok_src_i), .sync_logic_signal_select_i(sync_logic_signal_select_i),
  .object_type_i(object_type_i), .sync_use_i(sync_use_i), .close_pulse_ms_i(close_pulse_ms_i),
  .open_req_i(open_req_i), .close_req_i(close_req_i), .open_interlock_i(open_interlock_i),
  .clear_stats_i(clear_stats_i), .open_cmd_o(open_cmd_o), .close_cmd_o(close_cmd_o),
  .close_ok_cnt_o(close_ok_cnt_o), .close_fail_cnt_o(close_fail_cnt_o), .clear_stats_o(clear_stats_o),
  .busy_o(busy_o));
`default_nettype wire

// >>> tb/swobj_breaker_model.sv
// behavioural breaker answering command pulses with position contacts
`timescale 1ns/1ps
`default_nettype none
module swobj_breaker_model #(
  parameter int DLY = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic open_cmd_i,
  input wire logic close_cmd_i,
  input wire logic stuck_i,
  output logic open_pos_o,
  output logic closed_pos_o
);
  logic closed_q;
  int cnt;
  // a stuck mechanism never leaves its end position
  always @(posedge clk_i) begin
    if (srst_i) begin
      closed_q <= 1'b0;
      cnt <= 0;
    end else if (!stuck_i && (closed_q ? open_cmd_i : close_cmd_i)) begin
      cnt <= (cnt == DLY) ? 0 : cnt + 1;
      if (cnt == DLY) closed_q <= !closed_q;
    end
  end
  // both contacts low while travelling
  assign open_pos_o = !closed_q && cnt == 0;
  assign closed_pos_o = closed_q && cnt == 0;
endmodule
`default_nettype wire

// >>> tb/swobj_ctrl_bench.sv
// self-checking bench for the switchgear object control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, y) begin tests_run++; if ((y) !== (x)) begin error_cnt++; $display("[ERR] %s exp %0h got %0h", n, x, y); end end
module swobj_ctrl_bench;
  logic clk = 1'b0, srst = 1'b1, oreq = 1'b0, creq = 1'b0, il = 1'b0, clr = 1'b0, stuck = 1'b0;
  logic su = 1'b0, sy = 1'b0, rd = 1'b0, rin = 1'b1, err_seen = 1'b0, closed = 1'b0, clr_seen = 1'b0;
  logic [2:0] orly = 3'h5, crly = 3'h2;
  logic [1:0] typ = 2'h1, ru = 2'h2, osel = 2'h2, csel = 2'h2, gsel = 2'h2;
  logic opos, cpos, ocmd, ccmd, bsy, err, clro;
  logic [7:0] relay, rly;
  logic [1:0] bst;
  logic [2:0] cst;
  logic [31:0] c_ook, c_cok, c_ofl, c_cfl;
  logic [31:0] e [4] = '{32'h0, 32'h0, 32'h0, 32'h0};
  logic [11:0] r;
  // op, type, sync use, sync, ready use, ready, interlock, outcome 0 done 1 refused 2 ignored
  logic [11:0] rows [14] = '{12'hb90, 12'h240, 12'hb41, 12'ha40, 12'h440, 12'ha01, 12'h820,
    12'h040, 12'hd00, 12'h642, 12'h240, 12'ha31, 12'ha49, 12'h249};
  int error_cnt = 0;
  int tests_run = 0;
  int k;
  initial forever #12.5 clk = ~clk;
  swobj_ctrl #(.TICK_CYC(4)) u_swobj_ctrl (
    .core_clk_i(clk), .srst_i(srst), .open_pos_src_i({1'b1, opos, 2'h0}), .closed_pos_src_i({1'b1, cpos, 2'h0}),
    .racked_in_src_i({1'b1, rin, 2'h0}), .racked_out_src_i({1'b1, !rin, 2'h0}),
    .ready_src_i({1'b1, rd, 2'h0}), .sync_ok_src_i({1'b1, sy, 2'h0}),
    .open_logic_signal_select_i(osel), .closed_logic_signal_select_i(csel), .in_logic_signal_select_i(gsel),
    .out_logic_signal_select_i(gsel), .ready_logic_signal_select_i(gsel), .sync_logic_signal_select_i(gsel),
    .object_type_i(typ), .sync_use_i(su), .ready_use_i(ru), .open_pulse_ms_i(16'h0005),
    .close_pulse_ms_i(16'h0005), .term_ms_i(16'h000a), .open_output_relay_select_i(orly),
    .close_output_relay_select_i(crly), .open_req_i(oreq), .close_req_i(creq), .open_interlock_i(il),
    .close_interlock_i(il), .clear_stats_i(clr), .relay_o(relay), .open_cmd_o(ocmd), .close_cmd_o(ccmd),
    .breaker_status_o(bst), .cart_status_o(cst), .open_ok_cnt_o(c_ook), .close_ok_cnt_o(c_cok),
    .open_fail_cnt_o(c_ofl), .close_fail_cnt_o(c_cfl), .clear_stats_o(clro), .ctrl_error_o(err), .busy_o(bsy));
  swobj_breaker_model u_swobj_breaker_model (.clk_i(clk), .srst_i(srst), .open_cmd_i(ocmd),
    .close_cmd_i(ccmd), .stuck_i(stuck), .open_pos_o(opos), .closed_pos_o(cpos));
  always @(posedge clk) begin
    if (err === 1'b1) err_seen <= 1'b1;
    if (clro === 1'b1) clr_seen <= 1'b1;
  end
  task finish_test;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one request pulse, then wait for the control to settle
  task req(input logic op);
    @(posedge clk);
    if (op) creq <= 1'b1;
    else oreq <= 1'b1;
    @(posedge clk);
    creq <= 1'b0;
    oreq <= 1'b0;
    repeat (2) @(posedge clk);
    #1 rly = relay;
    @(posedge clk);
    for (k = 0; k < 400 && bsy !== 1'b0; k++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task check_all;
    `CHK("counters", {e[0], e[1], e[2], e[3]}, {c_ook, c_cok, c_ofl, c_cfl})
    `CHK("breaker", closed ? 2'h2 : 2'h1, bst)
    `CHK("cart", typ == 2'h0 ? 3'h2 : 3'h4, cst)
  endtask
  initial begin
    #(25 * 20000);
    error_cnt++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (5) @(posedge clk);
    check_all;
    $display("reset done");
    for (int i = 0; i < 14; i++) begin
      r = rows[i];
      @(posedge clk);
      {typ, su, sy, ru, rd, il} <= r[10:3];
      repeat (6) @(posedge clk);
      req(r[11]);
      if (r[1:0] == 2'h0) begin
        e[r[11]]++;
        closed = r[11];
      end else if (r[1:0] == 2'h1) e[2 + r[11]]++;
      check_all;
      `CHK("relay", r[1:0] == 2'h0 ? 8'h01 << (r[11] ? crly : orly) : 8'h00, rly)
      $display("row %0d done", i);
    end
    @(posedge clk);
    {typ, su, ru, il, stuck, crly} <= {2'h1, 1'b0, 2'h2, 1'b0, 1'b1, 3'h7};
    repeat (6) @(posedge clk);
    req(1'b1);
    e[3]++;
    `CHK("timeout", 1'b1, err_seen)
    `CHK("relay sel", 8'h80, rly)
    check_all;
    stuck <= 1'b0;
    $display("timeout done");
    @(posedge clk);
    {typ, rin} <= {2'h0, 1'b0};
    repeat (6) @(posedge clk);
    `CHK("cart out", 3'h1, cst)
    req(1'b1);
    e[3]++;
    `CHK("cart lock", 8'h00, rly)
    rin <= 1'b1;
    repeat (5) @(posedge clk);
    check_all;
    $display("cart done");
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (4) @(posedge clk);
    e = '{32'h0, 32'h0, 32'h0, 32'h0};
    check_all;
    `CHK("clear idle", 1'b0, clro)
    `CHK("clear pulse", 1'b1, clr_seen)
    $display("clear done");
    {osel, csel} <= 4'hf;
    repeat (5) @(posedge clk);
    `CHK("bad", 2'h3, bst)
    {osel, csel} <= 4'h0;
    repeat (5) @(posedge clk);
    `CHK("mid", 2'h0, bst)
    $display("status done");
    finish_test;
  end
endmodule
`default_nettype wire
